//--- psq_pkg.sv
/*
  package for the program sequencer: address widths, vectors, reach masks,
  stack depth and the command encoding driven by the instruction decoder.
  assumes a single core clock domain.
*/
package psq_pkg;
  localparam int unsigned PC_W        = 10;
  localparam int unsigned STK_DEPTH   = 8;
  localparam int unsigned STK_PTR_W   = 3;
  localparam logic [9:0]  RESET_VEC   = 10'h000;
  localparam logic [9:0]  SWI_VEC     = 10'h001;
  localparam logic [9:0]  HWI_VEC     = 10'h008;
  localparam logic [9:0]  SHORT_MASK  = 10'h0FF;
  localparam logic [9:0]  MEDIUM_MASK = 10'h1FF;
  localparam logic [9:0]  RSVD_LO     = 10'h3FE;
  localparam logic [9:0]  ROLL_LO     = 10'h00E;
  localparam logic [9:0]  ROLL_HI     = 10'h00F;

  // command from the decoder, one per instruction cycle
  typedef enum logic [3:0] {
    PSQ_CMD_NEXT       = 4'h0,
    PSQ_CMD_SHORT_CALL = 4'h1,
    PSQ_CMD_SHORT_JUMP = 4'h2,
    PSQ_CMD_SHORT_ACAL = 4'h3,
    PSQ_CMD_MED_JUMP   = 4'h4,
    PSQ_CMD_LONG_CALL  = 4'h5,
    PSQ_CMD_LONG_JUMP  = 4'h6,
    PSQ_CMD_RETURN     = 4'h7,
    PSQ_CMD_RET_LIT    = 4'h8,
    PSQ_CMD_RET_INT    = 4'h9,
    PSQ_CMD_SOFT_INT   = 4'hA,
    PSQ_CMD_HOLD       = 4'hB
  } psq_cmd_t;
endpackage

//--- psq_return_stack.sv
/*
  eight-entry circular return stack.
  assumes the caller never pushes and pops in the same cycle.
*/
`timescale 1ns/10ps
module psq_return_stack
  import psq_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                clk_en_i,
  input  wire logic                push_i,
  input  wire logic                pop_i,
  input  wire logic [PC_W-1:0]     push_addr_i,
  output logic      [PC_W-1:0]     top_o,
  output logic      [STK_PTR_W:0]  fill_o
);
  logic [PC_W-1:0]      stk_mem [STK_DEPTH];
  logic [STK_PTR_W-1:0] ptr_r;
  logic [STK_PTR_W:0]   fill_r;

  ////////////////////////////////////////////////////////////////////////
  // pointer: wraps silently, overflow drops the oldest entry
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ptr_r <= 3'h0;
    end else if (clk_en_i && push_i) begin
      ptr_r <= ptr_r + 3'h1;
    end else if (clk_en_i && pop_i) begin
      ptr_r <= ptr_r - 3'h1;
    end
  end

  // occupancy count saturates, no error is raised
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fill_r <= 4'h0;
    end else if (clk_en_i && push_i && fill_r != 4'h8) begin
      fill_r <= fill_r + 4'h1;
    end else if (clk_en_i && pop_i && !push_i && fill_r != 4'h0) begin
      fill_r <= fill_r - 4'h1;
    end
  end

  // storage: no reset; a pop on an empty stack reads whatever the slot last held
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && push_i) begin
      stk_mem[ptr_r] <= push_addr_i;
    end
  end

  assign top_o  = stk_mem[ptr_r - 3'h1];
  assign fill_o = fill_r;
endmodule // psq_return_stack

//--- psq_program_sequencer.sv
/*
  program counter and call/return sequencing for a 1K-word program memory.
  hardware interrupt requests outrank the instruction of the same cycle and
  save pc+1 as their return point; a hold command blocks them so a stalled
  fetch never loses its place. popping an empty stack hands back whatever
  the slot last held, with no flag: firmware keeps calls and returns paired.
  the stack keeps eight entries and overwrites the oldest when overrun.
  the reserved top pair of addresses is only reported, never trapped.
  assumes the decoder issues one command per enabled cycle and that pin
  inputs (external interrupt) are asynchronous to core_clk_i.
*/
`timescale 1ns/10ps
module psq_program_sequencer
  import psq_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     clk_en_i,
  input  wire psq_pkg::psq_cmd_t        cmd_i,
  input  wire logic [psq_pkg::PC_W-1:0] target_i,
  input  wire logic [7:0]               literal_i,
  input  wire logic                     int_req_i,
  input  wire logic                     port_b0_i,
  input  wire logic                     ext_irq_select_i,
  input  wire logic                     ext_irq_enable_i,
  output logic      [psq_pkg::PC_W-1:0] pc_o,
  output logic      [7:0]               ret_literal_o,
  output logic                          ret_literal_vld_o,
  output logic                          ext_irq_o,
  output logic                          int_entry_o,
  output logic                          stack_full_o,
  output logic                          rsvd_fetch_o
);
  import psq_pkg::*;

  // counter, stack hook-up and the registered status outputs
  logic [PC_W-1:0]    pc_r;
  logic [PC_W-1:0]    pc_nxt;
  logic [PC_W-1:0]    pc_inc;
  logic [PC_W-1:0]    stk_top;
  logic [STK_PTR_W:0] stk_fill;
  logic               push;
  logic               pop;
  logic               hw_take;
  logic               pb0_s1_r;
  logic               pb0_s2_r;
  logic               pb0_d_r;
  logic               ext_irq_r;
  logic               int_entry_r;
  logic [7:0]         lit_r;
  logic               lit_vld_r;
  logic               full_r;
  logic               rsvd_r;

  // page-relative target inside a reach window
  function automatic logic [PC_W-1:0] reach(input logic [PC_W-1:0] base,
                                            input logic [PC_W-1:0] tgt,
                                            input logic [PC_W-1:0] mask);
    reach = (base & ~mask) | (tgt & mask);
  endfunction

  // return-with-literal accepted this cycle, decoded for value and strobe
  function automatic logic lit_taken(input logic hw, input psq_cmd_t cmd);
    lit_taken = ~hw & (cmd == PSQ_CMD_RET_LIT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // external interrupt pin: two-flop sync, then rising-edge detect
  // only the second flop feeds logic, the first may still be settling
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pb0_s1_r <= 1'b0;
      pb0_s2_r <= 1'b0;
      pb0_d_r  <= 1'b0;
    end else if (clk_en_i) begin
      pb0_s1_r <= port_b0_i;
      pb0_s2_r <= pb0_s1_r;
      pb0_d_r  <= pb0_s2_r;
    end
  end

  // pin acts as interrupt source only when both bits are set
  // rising edge only, so a pin held high raises a single request
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_irq_r <= 1'b0;
    end else if (clk_en_i) begin
      ext_irq_r <= ext_irq_select_i & ext_irq_enable_i & pb0_s2_r & ~pb0_d_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next-address selection; hardware interrupts win over every instruction except hold
  // the increment also feeds the stack, so a call saves the word after itself
  assign pc_inc  = pc_r + 10'h001;
  assign hw_take = int_req_i & (cmd_i != PSQ_CMD_HOLD);

  always_comb begin
    pc_nxt = pc_inc;
    push   = 1'b0;
    pop    = 1'b0;
    if (hw_take) begin
      pc_nxt = HWI_VEC;
      push   = 1'b1;
    end else begin
      // short and medium forms keep the page bits of the current counter
      unique case (cmd_i)
        PSQ_CMD_NEXT: begin
          pc_nxt = pc_inc;
        end
        PSQ_CMD_SHORT_CALL, PSQ_CMD_SHORT_ACAL: begin
          pc_nxt = reach(pc_r, target_i, SHORT_MASK);
          push   = 1'b1;
        end
        PSQ_CMD_SHORT_JUMP: begin
          pc_nxt = reach(pc_r, target_i, SHORT_MASK);
        end
        PSQ_CMD_MED_JUMP: begin
          pc_nxt = reach(pc_r, target_i, MEDIUM_MASK);
        end
        PSQ_CMD_LONG_CALL: begin
          pc_nxt = target_i;
          push   = 1'b1;
        end
        PSQ_CMD_LONG_JUMP: begin
          pc_nxt = target_i;
        end
        PSQ_CMD_RETURN, PSQ_CMD_RET_LIT, PSQ_CMD_RET_INT: begin
          pc_nxt = stk_top;
          pop    = 1'b1;
        end
        PSQ_CMD_SOFT_INT: begin
          pc_nxt = SWI_VEC;
          push   = 1'b1;
        end
        PSQ_CMD_HOLD: begin
          pc_nxt = pc_r;
        end
        default: begin
          pc_nxt = pc_inc;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // program counter, ten bits, starts at the reset vector
  // a low clock enable holds it, so the fetch simply repeats the same word
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pc_r <= RESET_VEC;
    end else if (clk_en_i) begin
      pc_r <= pc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // return literal captured for the accumulator on a return-with-literal
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lit_r     <= 8'h00;
      lit_vld_r <= 1'b0;
    end else if (clk_en_i) begin
      lit_vld_r <= lit_taken(hw_take, cmd_i);
      if (lit_taken(hw_take, cmd_i)) begin
        lit_r <= literal_i;
      end
    end
  end

  // status flags; reserved-area fetch is only reported, software must avoid it
  // full is only a hint: a ninth push still overwrites the oldest entry
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      int_entry_r <= 1'b0;
      full_r      <= 1'b0;
      rsvd_r      <= 1'b0;
    end else if (clk_en_i) begin
      int_entry_r <= hw_take;
      full_r      <= (stk_fill == 4'h8);
      rsvd_r      <= (pc_nxt >= RSVD_LO);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // return stack, next address is pushed
  // push and pop never coincide: the command decode raises one at most
  psq_return_stack u_stack (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .clk_en_i    (clk_en_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_addr_i (pc_inc),
    .top_o       (stk_top),
    .fill_o      (stk_fill)
  );

  ////////////////////////////////////////////////////////////////////////
  // every output is a flop, no logic between register and port
  assign pc_o              = pc_r;
  assign ret_literal_o     = lit_r;
  assign ret_literal_vld_o = lit_vld_r;
  assign ext_irq_o         = ext_irq_r;
  assign int_entry_o       = int_entry_r;
  assign stack_full_o      = full_r;
  assign rsvd_fetch_o      = rsvd_r;
endmodule // psq_program_sequencer

//--- psq_seq_assertions.sv
/* port checks for the program sequencer.
   assumes one clock domain; bound to the sequencer below. */
`timescale 1ns/10ps
module psq_seq_assertions
  import psq_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              sys_rst_i,
  input wire logic              clk_en_i,
  input wire psq_pkg::psq_cmd_t cmd_i,
  input wire logic [9:0]        target_i,
  input wire logic [7:0]        literal_i,
  input wire logic              int_req_i,
  input wire logic              ext_irq_select_i,
  input wire logic              ext_irq_enable_i,
  input wire logic [9:0]        pc_o,
  input wire logic [7:0]        ret_literal_o,
  input wire logic              ret_literal_vld_o,
  input wire logic              ext_irq_o,
  input wire logic              int_entry_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // instruction taken, not pre-empted by a hardware interrupt
  logic go;
  assign go = clk_en_i && !int_req_i;
  sequence s_call;
    go && cmd_i == PSQ_CMD_LONG_CALL;
  endsequence
  sequence s_ret;
    go && cmd_i inside {PSQ_CMD_RETURN, PSQ_CMD_RET_INT};
  endsequence
  property p_next;
    go && cmd_i == PSQ_CMD_NEXT |=> pc_o == $past(pc_o) + 10'h001;
  endproperty
  property p_hold;
    !clk_en_i || cmd_i == PSQ_CMD_HOLD |=> $stable(pc_o);
  endproperty
  property p_swi;
    go && cmd_i == PSQ_CMD_SOFT_INT |=> pc_o == SWI_VEC;
  endproperty
  property p_hwi;
    clk_en_i && int_req_i && cmd_i != PSQ_CMD_HOLD |=> pc_o == HWI_VEC && int_entry_o;
  endproperty
  property p_short;
    go && cmd_i inside {PSQ_CMD_SHORT_CALL, PSQ_CMD_SHORT_JUMP, PSQ_CMD_SHORT_ACAL} |=>
      (pc_o & SHORT_MASK) == ($past(target_i) & SHORT_MASK) &&
      (pc_o & ~SHORT_MASK) == ($past(pc_o) & ~SHORT_MASK);
  endproperty
  property p_med;
    go && cmd_i == PSQ_CMD_MED_JUMP |=> (pc_o & MEDIUM_MASK) == ($past(target_i) & MEDIUM_MASK) &&
      (pc_o & ~MEDIUM_MASK) == ($past(pc_o) & ~MEDIUM_MASK);
  endproperty
  property p_long;
    go && cmd_i inside {PSQ_CMD_LONG_CALL, PSQ_CMD_LONG_JUMP} |=> pc_o == $past(target_i);
  endproperty
  property p_callret;
    s_call ##1 s_ret |=> pc_o == $past(pc_o, 2) + 10'h001;
  endproperty
  property p_retlit;
    go && cmd_i == PSQ_CMD_RET_LIT |=> ret_literal_vld_o && ret_literal_o == $past(literal_i);
  endproperty
  property p_ext;
    ext_irq_o |-> $past(ext_irq_select_i) && $past(ext_irq_enable_i);
  endproperty
  a_next: assert property (p_next)
    else $error("pc did not step");
  a_hold: assert property (p_hold)
    else $error("pc moved while frozen");
  a_swi: assert property (p_swi)
    else $error("soft interrupt vector wrong");
  a_hwi: assert property (p_hwi)
    else $error("hardware interrupt vector wrong");
  a_short: assert property (p_short)
    else $error("short branch reach wrong");
  a_med: assert property (p_med)
    else $error("medium jump reach wrong");
  a_long: assert property (p_long)
    else $error("long branch target wrong");
  a_callret: assert property (p_callret)
    else $error("return address wrong");
  a_retlit: assert property (p_retlit)
    else $error("returned literal wrong");
  a_ext: assert property (p_ext)
    else $error("pin interrupt while disabled");
endmodule // psq_seq_assertions

bind psq_program_sequencer psq_seq_assertions i_chk (.core_clk_i, .sys_rst_i, .clk_en_i, .cmd_i, .target_i,
  .literal_i, .int_req_i, .ext_irq_select_i, .ext_irq_enable_i, .pc_o, .ret_literal_o, .ret_literal_vld_o,
  .ext_irq_o, .int_entry_o);

//--- psq_rom_model.sv
/* program memory model on the fetch side.
   assumes pc_i is the registered program counter. */
`timescale 1ns/10ps
module psq_rom_model (
  input  wire logic [9:0]  pc_i,
  output logic      [13:0] word_o
);
  // no code in the reserved top pair: flipped pattern, never a real word
  always_comb begin
    if (pc_i >= 10'h3FE) begin
      word_o = {4'hF, ~pc_i};
    end else begin
      word_o = {4'h0, pc_i};
    end
  end
endmodule // psq_rom_model

//--- tb_top.sv
/* directed testbench for the program sequencer.
   assumes the checker binds itself to the sequencer. */
`timescale 1ns/10ps
module tb_top;
  import psq_pkg::*;
  logic core_clk_i, sys_rst_i, clk_en_i, int_req_i, port_b0_i, ext_irq_select_i, ext_irq_enable_i;
  logic ret_literal_vld_o, ext_irq_o, int_entry_o, stack_full_o, rsvd_fetch_o;
  psq_cmd_t    cmd_i;
  logic [9:0]  target_i, pc_o;
  logic [7:0]  literal_i, ret_literal_o;
  logic [13:0] rom_word;
  int          errors, checks_done;
  psq_program_sequencer i_dut (.core_clk_i, .sys_rst_i, .clk_en_i, .cmd_i, .target_i, .literal_i, .int_req_i,
    .port_b0_i, .ext_irq_select_i, .ext_irq_enable_i, .pc_o, .ret_literal_o, .ret_literal_vld_o, .ext_irq_o,
    .int_entry_o, .stack_full_o, .rsvd_fetch_o);
  psq_rom_model i_rom (.pc_i(pc_o), .word_o(rom_word));
  // 125 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk_a(logic [9:0] got, logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(logic got, logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  // inputs change 1 ns after the edge, outputs read there too
  task automatic step(psq_cmd_t c, logic [9:0] t);
    cmd_i = c;
    target_i = t;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_branches;
    psq_cmd_t sc[3] = '{PSQ_CMD_SHORT_CALL, PSQ_CMD_SHORT_JUMP, PSQ_CMD_SHORT_ACAL};
    chk_a(pc_o, RESET_VEC);
    foreach (sc[i]) begin
      step(PSQ_CMD_LONG_JUMP, 10'h2A5);
      chk_a(pc_o, 10'h2A5);
      step(sc[i], 10'h3C4);
      chk_a(pc_o, 10'h2C4);
    end
    step(PSQ_CMD_MED_JUMP, 10'h1C4);
    chk_a(pc_o, 10'h3C4);
    step(PSQ_CMD_SOFT_INT, 10'h000);
    chk_a(pc_o, SWI_VEC);
    int_req_i = 1'b1;
    step(PSQ_CMD_NEXT, 10'h000);
    int_req_i = 1'b0;
    chk_a(pc_o, HWI_VEC);
    chk_b(int_entry_o, 1'b1);
    step(PSQ_CMD_RET_INT, 10'h000);
    chk_a(pc_o, 10'h002);
    chk_b(int_entry_o, 1'b0);
  endtask
  // nine nested calls: the oldest return address must be lost
  task automatic t_stack;
    for (int i = 0; i < 9; i++) begin
      step(PSQ_CMD_LONG_CALL, 10'h100 + 10'(i));
      if (i == 7) begin
        step(PSQ_CMD_HOLD, 10'h000);
        chk_b(stack_full_o, 1'b1);
      end
    end
    for (int i = 8; i > 0; i--) begin
      step(PSQ_CMD_RETURN, 10'h000);
      chk_a(pc_o, 10'h100 + 10'(i));
    end
    chk_b(stack_full_o, 1'b0);
    literal_i = 8'hA5;
    step(PSQ_CMD_RET_LIT, 10'h000);
    chk_b(ret_literal_vld_o, 1'b1);
    chk_a({2'b00, ret_literal_o}, 10'h0A5);
  endtask
  // top of memory, wrap, freeze and the released rolling-code words
  task automatic t_edges;
    step(PSQ_CMD_LONG_JUMP, 10'h3FE);
    chk_b(ret_literal_vld_o, 1'b0);
    step(PSQ_CMD_HOLD, 10'h000);
    chk_b(rsvd_fetch_o, 1'b1);
    chk_a(rom_word[9:0], 10'h001);
    clk_en_i = 1'b0;
    step(PSQ_CMD_NEXT, 10'h000);
    chk_a(pc_o, 10'h3FE);
    clk_en_i = 1'b1;
    step(PSQ_CMD_NEXT, 10'h000);
    step(PSQ_CMD_NEXT, 10'h000);
    chk_a(pc_o, RESET_VEC);
    step(PSQ_CMD_LONG_JUMP, ROLL_LO);
    step(PSQ_CMD_NEXT, 10'h000);
    chk_a(pc_o, ROLL_HI);
    step(PSQ_CMD_NEXT, 10'h000);
    chk_a(pc_o, 10'h010);
    chk_b(rsvd_fetch_o, 1'b0);
  endtask
  // pin edge counts only with select and enable both set
  task automatic t_ext;
    int n;
    for (int k = 1; k < 4; k++) begin
      {ext_irq_select_i, ext_irq_enable_i} = k[1:0];
      port_b0_i = 1'b0;
      repeat (4) step(PSQ_CMD_NEXT, 10'h000);
      port_b0_i = 1'b1;
      n = 0;
      repeat (8) begin
        step(PSQ_CMD_NEXT, 10'h000);
        if (ext_irq_o === 1'b1) n++;
      end
      chk_a(10'(n), (k == 3) ? 10'h001 : 10'h000);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    checks_done = 0;
    {sys_rst_i, clk_en_i} = 2'b11;
    {int_req_i, port_b0_i, ext_irq_select_i, ext_irq_enable_i} = 4'h0;
    cmd_i = PSQ_CMD_NEXT;
    target_i = 10'h000;
    literal_i = 8'h00;
    repeat (3) @(posedge core_clk_i);
    #1 sys_rst_i = 1'b0;
    t_branches();
    t_stack();
    t_edges();
    t_ext();
    report_and_stop();
  end
  // hang guard, far beyond the 76 cycles used
  initial begin
    #20000;
    errors++;
    report_and_stop();
  end
endmodule // tb_top
